// ---- lcs_regs.vh ----
// constants shared by the lamp controller serial slave port
`ifndef LCS_REGS_VH
`define LCS_REGS_VH
`define LCS_ADDR_FIXED      6'h28
`define LCS_BYTE_BITS       4'h8
`define LCS_BIT_ZERO        4'h0
`define LCS_DIR_READ        1'b1
`define LCS_ACK_LEVEL       1'b0
`define LCS_NVW_TIME_MS     10
`define LCS_CLK_MHZ         100
`define LCS_NVW_CYCLES      (`LCS_NVW_TIME_MS * 1000 * `LCS_CLK_MHZ)
`define LCS_FIFO_WIDTH      16
`define LCS_FIFO_DEPTH      4
`define LCS_FIFO_AW         2
`define LCS_MEM_AW          8
`define LCS_MEM_DW          8
`endif

// ---- lcs_fifo.v ----
// small valid/ready fifo for write requests
`timescale 1ns/1ps
module lcs_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage
    reg [AW-1:0]    wr_ptr_reg;          // write pointer
    reg [AW-1:0]    rd_ptr_reg;          // read pointer
    reg [AW:0]      count_reg;           // fill level
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write, no reset needed
    always @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and level
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ---- lcs_mem.v ----
// user memory with registered read data
`timescale 1ns/1ps
module lcs_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    // clock
    input  wire          clk,
    // write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // read port, data one cycle later
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem_reg [0:(1<<AW)-1]; // array

    // write and registered read
    always @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule

// ---- lcs_i2c_slave.v ----
// two-wire slave port of the lamp controller
`timescale 1ns/1ps
`include "lcs_regs.vh"
module lcs_i2c_slave #(
    parameter NVW_CYCLES = `LCS_NVW_CYCLES
) (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe_n,
    // strap
    input  wire       address_select_pin,
    // status
    output reg        busy,
    output reg        bus_idle
);
    // one-hot states
    localparam ST_IDLE = 6'h01; // waiting for start
    localparam ST_ADDR = 6'h02; // address byte
    localparam ST_LOC  = 6'h04; // memory location byte
    localparam ST_WDAT = 6'h08; // write data byte
    localparam ST_RDAT = 6'h10; // read data byte
    localparam ST_IGN  = 6'h20; // ignoring until start

    // reset release: asserted at once, removed through two flops
    // so that no register leaves reset on a different clock edge
    reg rst_s1_reg; // first release stage
    reg rst_n_reg;  // released reset used by the rest
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // hold both stages in reset
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            // walk the release through
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // pin synchronisers plus one history stage
    reg [1:0] scl_s_reg;  // [0] first stage only
    reg [1:0] sda_s_reg;
    reg       scl_d_reg;  // previous synced clock
    reg       sda_d_reg;  // previous synced data
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            // bus lines rest high
            scl_s_reg <= 2'h3;
            sda_s_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            // pin levels step through
            scl_s_reg <= {scl_s_reg[0], scl_in};
            sda_s_reg <= {sda_s_reg[0], sda_in};
            scl_d_reg <= scl_s_reg[1];
            sda_d_reg <= sda_s_reg[1];
        end
    end

    // settled bus levels and the events seen on them;
    // these lag the pins by two clocks, far below a bus half period
    wire scl = scl_s_reg[1];
    wire sda = sda_s_reg[1];
    wire scl_rise = scl & ~scl_d_reg;
    wire scl_fall = ~scl & scl_d_reg;
    wire start_ev = scl & scl_d_reg & sda_d_reg & ~sda;
    wire stop_ev  = scl & scl_d_reg & ~sda_d_reg & sda;

    // strap caught after reset release, two stages as it is a pin
    reg sel_s1_reg; // first stage, read only by the second
    reg sel_reg;    // settled strap level
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            // both stages start low
            sel_s1_reg <= 1'b0;
            sel_reg    <= 1'b0;
        end else begin
            // pass the pin level through
            sel_s1_reg <= address_select_pin;
            sel_reg    <= sel_s1_reg;
        end
    end

    // protocol state
    reg [5:0]  state_reg;
    reg [3:0]  bit_cnt_reg;  // bits taken in this byte
    reg [7:0]  shift_reg;    // receive or transmit shift
    reg        ack_ph_reg;   // in ninth bit
    reg        rd_dir_reg;   // current transfer is a read
    reg [7:0]  loc_reg;      // memory location pointer
    reg        wrote_reg;    // a write was queued this transfer
    reg [31:0] nvw_cnt_reg;  // programming countdown
    reg        mstr_nack_reg; // master refused a read byte

    // fifo and memory wiring
    // queue entries carry location and data together
    reg         q_valid;
    wire        q_ready;
    wire        m_valid;
    wire [15:0] m_data;
    wire [7:0]  rd_data;

    // write queue between the bus side and the programming side;
    // a full queue makes the data byte go unacknowledged
    lcs_fifo #(
        .WIDTH (`LCS_FIFO_WIDTH),
        .DEPTH (`LCS_FIFO_DEPTH),
        .AW    (`LCS_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n_reg),
        .in_valid  (q_valid),
        .in_ready  (q_ready),
        .in_data   ({loc_reg, shift_reg}),
        .out_valid (m_valid),
        .out_ready (busy),
        .out_data  (m_data)
    );

    // programming commits entries while busy
    lcs_mem #(
        .AW (`LCS_MEM_AW),
        .DW (`LCS_MEM_DW)
    ) u_mem (
        .clk     (clk),
        .wr_en   (m_valid & busy),
        .wr_addr (m_data[15:8]),
        .wr_data (m_data[7:0]),
        .rd_addr (loc_reg),
        .rd_data (rd_data)
    );

    // address match on completed first byte
    // the strap supplies the lowest address bit
    wire addr_hit = (shift_reg[7:2] == `LCS_ADDR_FIXED) &&
                    (shift_reg[1] == sel_reg);

    // queue a write at data byte end
    // one push per data byte, on the fall that ends its eighth bit
    always @* begin
        q_valid = 1'b0;
        if (state_reg == ST_WDAT && !ack_ph_reg && scl_fall &&
            bit_cnt_reg == `LCS_BYTE_BITS) begin
            q_valid = 1'b1;
        end
    end

    // main protocol engine
    // every drive change is made a few clocks after a bus clock fall,
    // so the data line only moves while the bus clock is low
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            // released line, idle bus, no programming
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= `LCS_BIT_ZERO;
            shift_reg     <= 8'h00;
            ack_ph_reg    <= 1'b0;
            rd_dir_reg    <= 1'b0;
            loc_reg       <= 8'h00;
            wrote_reg     <= 1'b0;
            sda_out       <= 1'b0;
            sda_oe_n      <= 1'b1;
            busy          <= 1'b0;
            bus_idle      <= 1'b1;
            nvw_cnt_reg   <= 32'h0;
            mstr_nack_reg <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            // programming timer after nv write stop
            if (busy) begin
                if (nvw_cnt_reg == 32'h0) begin
                    // hold busy until the queue is drained too
                    if (!m_valid) begin
                        busy <= 1'b0;
                    end
                end else begin
                    // count the programming time down
                    nvw_cnt_reg <= nvw_cnt_reg - 32'h1;
                end
            end
            if (start_ev) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= `LCS_BIT_ZERO;
                ack_ph_reg  <= 1'b0;
                sda_oe_n    <= 1'b1;
                bus_idle    <= 1'b0;
            end else if (stop_ev) begin
                state_reg   <= ST_IDLE;
                bit_cnt_reg <= `LCS_BIT_ZERO;
                ack_ph_reg  <= 1'b0;
                sda_oe_n    <= 1'b1;
                bus_idle    <= 1'b1;
                // a queued write starts programming
                if (wrote_reg) begin
                    busy        <= 1'b1;
                    nvw_cnt_reg <= NVW_CYCLES - 1;
                    wrote_reg   <= 1'b0;
                end
            end else if (state_reg == ST_IDLE || state_reg == ST_IGN) begin
                sda_oe_n <= 1'b1;
            end else if (scl_rise && !ack_ph_reg) begin
                // msb first shift in
                // read bits are only counted, not taken in
                if (state_reg != ST_RDAT) begin
                    shift_reg <= {shift_reg[6:0], sda};
                end
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_rise && ack_ph_reg) begin
                mstr_nack_reg <= (state_reg == ST_RDAT) && sda;
            end else if (scl_fall) begin
                // bus clock fall: end of a bit
                if (!ack_ph_reg && bit_cnt_reg == `LCS_BYTE_BITS) begin
                    // ninth bit begins
                    ack_ph_reg <= 1'b1;
                    case (state_reg)
                        ST_ADDR: begin
                            // programming refuses the address as well
                            if (addr_hit && !busy) begin
                                sda_oe_n   <= `LCS_ACK_LEVEL;
                                rd_dir_reg <= shift_reg[0];
                            end else begin
                                sda_oe_n  <= 1'b1;
                                state_reg <= ST_IGN;
                            end
                        end
                        ST_LOC: begin
                            // location taken, acknowledge it
                            loc_reg  <= shift_reg;
                            sda_oe_n <= 1'b0;
                        end
                        ST_WDAT: begin
                            // refuse when queue full
                            sda_oe_n <= ~q_ready;
                            if (q_ready) begin
                                wrote_reg <= 1'b1;
                            end
                        end
                        ST_RDAT: begin
                            // release for the master answer, step location
                            sda_oe_n <= 1'b1;
                            loc_reg  <= loc_reg + 8'h1;
                        end
                        default: begin
                            // no other state reaches here
                            sda_oe_n <= 1'b1;
                        end
                    endcase
                end else if (ack_ph_reg) begin
                    // ninth bit ends, choose next byte
                    ack_ph_reg  <= 1'b0;
                    bit_cnt_reg <= `LCS_BIT_ZERO;
                    sda_oe_n    <= 1'b1;
                    case (state_reg)
                        ST_ADDR: begin
                            if (rd_dir_reg == `LCS_DIR_READ) begin
                                // read: first bit goes out at once
                                state_reg <= ST_RDAT;
                                shift_reg <= rd_data;
                                sda_oe_n  <= rd_data[7];
                            end else begin
                                // write: the location byte comes next
                                state_reg <= ST_LOC;
                            end
                        end
                        ST_LOC: begin
                            // data byte next
                            state_reg <= ST_WDAT;
                        end
                        ST_WDAT: begin
                            // one data byte per write, later ones refused
                            state_reg <= ST_IGN;
                        end
                        ST_RDAT: begin
                            if (mstr_nack_reg) begin
                                state_reg <= ST_IGN;
                            end else begin
                                // master wants more: load the next byte
                                shift_reg <= rd_data;
                                sda_oe_n  <= rd_data[7];
                            end
                        end
                        default: begin
                            // stray states fall back to ignoring
                            state_reg <= ST_IGN;
                        end
                    endcase
                end else if (state_reg == ST_RDAT) begin
                    shift_reg <= {shift_reg[6:0], 1'b1};
                    sda_oe_n  <= shift_reg[6];
                end
            end
        end
    end
endmodule

// ---- lcs_i2c_slave_properties.sv ----
// pin-level checks of the two-wire slave port
`timescale 1ns/1ps
module lcs_i2c_slave_props #(
    parameter NVW_CYCLES = 50
) (
    // clock and reset
    input logic clk,
    input logic resetn,
    // bus pins
    input logic scl_in,
    input logic sda_in,
    input logic sda_out,
    input logic sda_oe_n,
    // strap and status
    input logic address_select_pin,
    input logic busy,
    input logic bus_idle
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // length of the current busy stretch
    logic [31:0] busy_cnt_reg;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) busy_cnt_reg <= 32'h0;
        else busy_cnt_reg <= busy ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    a_drive_low_only: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while clock high");
    a_idle_on_stop: assert property ($rose(bus_idle) |-> scl_in && sda_in)
        else $error("idle raised without stop");
    a_idle_off_start: assert property ($fell(bus_idle) |-> scl_in && !sda_in)
        else $error("idle dropped without start");
    a_idle_released: assert property (bus_idle |-> sda_oe_n)
        else $error("data driven while idle");
    a_busy_no_ack: assert property (busy |-> sda_oe_n)
        else $error("data driven while busy");
    a_busy_after_stop: assert property ($rose(busy) |-> ##[0:2] bus_idle)
        else $error("busy began outside idle");
    a_busy_length: assert property (
        $fell(busy) |-> $past(busy_cnt_reg) >= NVW_CYCLES - 2)
        else $error("busy ended early");
endmodule
bind lcs_i2c_slave lcs_i2c_slave_props #(.NVW_CYCLES(NVW_CYCLES)) u_props (
    .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin), .busy(busy),
    .bus_idle(bus_idle));

// ---- lcs_master_model.sv ----
// two-wire bus master model facing the slave port
`timescale 1ns/1ps
module lcs_master_model (
    // clock
    input  logic clk,
    // bus lines
    output logic scl,
    output logic sda_low,
    input  logic sda
);
    // bus at rest: clock high, data released to the pull-up
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // pass n falling system clock edges
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // start, or repeated start from a low clock
    task automatic start();
        sda_low = 1'b0;
        wait_n(4);
        scl = 1'b1;
        wait_n(8);
        sda_low = 1'b1;
        wait_n(8);
        scl = 1'b0;
    endtask
    // stop from a low clock
    task automatic stop();
        wait_n(4);
        sda_low = 1'b1;
        wait_n(4);
        scl = 1'b1;
        wait_n(8);
        sda_low = 1'b0;
        wait_n(8);
    endtask
    // one 16-cycle bit: data set mid-low, line read mid-high
    task automatic bit_x(input logic b, output logic r);
        wait_n(4);
        sda_low = !b;
        wait_n(4);
        scl = 1'b1;
        wait_n(4);
        r = sda;
        wait_n(4);
        scl = 1'b0;
    endtask
    // byte out msb first, then read the acknowledge
    task automatic tx_byte(input logic [7:0] b, output logic ack_n);
        for (int i = 7; i >= 0; i--) bit_x(b[i], ack_n);
        bit_x(1'b1, ack_n);
    endtask
    // byte in, then ack or, on the last byte, nack
    task automatic rx_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(last, r);
    endtask
endmodule

// ---- tb_lamp_ctrl_i2c_slave_port.sv ----
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
`include "lcs_regs.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_lamp_ctrl_i2c_slave_port;
    localparam int NVW = 400;       // shortened programming time
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       sel = 1'b0;         // address strap
    logic       scl;
    logic       sda_low;            // master pulling data low
    logic       sda_out;
    logic       sda_oe_n;
    logic       busy;
    logic       bus_idle;
    logic       ack_n;
    logic [7:0] rd;
    int         fail_count = 0;
    int         checks_done = 0;
    // wired data line with pull-up
    wire sda_line = !(sda_low || !sda_oe_n);
    always #5 clk = ~clk;
    lcs_master_model m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda_line));
    lcs_i2c_slave #(.NVW_CYCLES(NVW)) dut (.clk(clk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_select_pin(sel), .busy(busy), .bus_idle(bus_idle));
    // address byte from the fixed part, strap bit and direction
    function automatic logic [7:0] adr(input logic s, input logic dir);
        return {`LCS_ADDR_FIXED, s, dir};
    endfunction
    // send one byte and judge the acknowledge
    task automatic send(input string nm, input logic [7:0] b, input logic ex);
        m.tx_byte(b, ack_n);
        `CHK(nm, ex, ack_n)
    endtask
    // single write, busy probe, wait out programming
    task automatic t_write(input logic s, input logic [7:0] loc, input logic [7:0] d);
        int n;
        sel = s;
        m.start();
        `CHK("idle_in_frame", 1'b0, bus_idle)
        send("adr_w", adr(s, 1'b0), 1'b0);
        send("loc", loc, 1'b0);
        send("data", d, 1'b0);
        m.stop();
        `CHK("idle_after_stop", 1'b1, bus_idle)
        `CHK("busy", 1'b1, busy)
        m.start();
        send("adr_busy", adr(s, 1'b0), 1'b1);
        m.stop();
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        `CHK("busy_end", 1'b0, busy)
        $display("test write done");
    endtask
    // random read of one or two bytes through a repeated start
    task automatic t_read(input logic s, input logic [7:0] loc, input int cnt,
                          input logic [7:0] e0, input logic [7:0] e1);
        sel = s;
        m.start();
        send("adr_w", adr(s, 1'b0), 1'b0);
        send("loc", loc, 1'b0);
        m.start();
        send("adr_r", adr(s, 1'b1), 1'b0);
        m.rx_byte(cnt == 1, rd);
        `CHK("rd0", e0, rd)
        if (cnt == 2) begin
            m.rx_byte(1'b1, rd);
            `CHK("rd1", e1, rd)
        end
        m.stop();
        `CHK("released", 1'b1, sda_oe_n)
        `CHK("drive_low", 1'b0, sda_out)
        $display("test read done");
    endtask
    // other address: no ack, following bytes ignored
    task automatic t_wrong();
        sel = 1'b1;
        m.start();
        send("adr_other", adr(1'b0, 1'b0), 1'b1);
        send("ignored", 8'h11, 1'b1);
        m.stop();
        `CHK("no_busy", 1'b0, busy)
        $display("test wrong address done");
    endtask
    // half byte cut short by a repeated start
    task automatic t_abort();
        sel = 1'b0;
        m.start();
        repeat (4) m.bit_x(1'b0, ack_n);
        t_read(1'b0, 8'h11, 1, 8'h3c, 8'h00);
        $display("test abort done");
    endtask
    // counts and verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("idle_reset", 1'b1, bus_idle)
        t_write(1'b0, 8'h10, 8'ha5);
        t_read(1'b0, 8'h10, 1, 8'ha5, 8'h00);
        t_write(1'b1, 8'h11, 8'h3c);
        t_read(1'b1, 8'h10, 2, 8'ha5, 8'h3c);
        t_wrong();
        t_abort();
        close_out();
    end
    // watchdog
    initial begin
        #300000; // about 30000 clocks, several times the whole test run
        fail_count++;
        close_out();
    end
endmodule
